// *** common/cmf_consts.vh ***
// constants for the chained math function block
// What this block does
// - five selectable inputs: operand a of stage one, operand b of stages one to four
// - each input normalised to percent from its own configured minimum and maximum
// - each normalised input times its weight, default 1.0, limited to -1.0..1.0
// - four stages chained, each stage output feeding operand a of the next
// - only stage one selects operand a; stages two to four select operand b only
// - operand b source code 0 means unused; stage passes operand a unchanged
// - operator codes 0..5 compare a with b: eq, ne, gt, ge, lt, le
// - operator codes 6, 7, 8 give logical or, and, xor
// - operator codes 9..12 give a plus, minus, times, divided by b
// - operator code 13 gives the smaller operand, code 14 the larger
// - logical operators treat an operand of at least 1 as true
// - comparison and logical stages emit exactly 0 or 1
// - arithmetic results saturate at full scale 0..100 percent
// - division by a zero divisor gives 100 percent
// - final percent mapped linearly onto configured output minimum..maximum
// - output minimum and maximum reported as this block's range limits
// - consumers select this block with source type 6 and instance 1..4
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH

`define CMF_DW            32
`define CMF_AW            8
`define CMF_NUM_IN        5
`define CMF_NUM_STAGE     4
`define CMF_NUM_SRC       8

// percent fixed point: 1 percent = 256 counts
`define CMF_PCT_FULL      32'h00006400
`define CMF_PCT_ONE       32'h00000100
`define CMF_PCT_ZERO      32'h00000000

// weight fixed point: 1.0 = 16384
`define CMF_WGT_ONE       16'h4000
`define CMF_WGT_NEG_ONE   16'hc000
`define CMF_WGT_FRAC      14

// operator codes
`define CMF_OP_EQ         4'h0
`define CMF_OP_NE         4'h1
`define CMF_OP_GT         4'h2
`define CMF_OP_GE         4'h3
`define CMF_OP_LT         4'h4
`define CMF_OP_LE         4'h5
`define CMF_OP_OR         4'h6
`define CMF_OP_AND        4'h7
`define CMF_OP_XOR        4'h8
`define CMF_OP_ADD        4'h9
`define CMF_OP_SUB        4'ha
`define CMF_OP_MUL        4'hb
`define CMF_OP_DIV        4'hc
`define CMF_OP_MIN        4'hd
`define CMF_OP_MAX        4'he

`define CMF_SRC_UNUSED    4'h0
`define CMF_SRC_TYPE_MATH 4'h6

// register map (word addresses)
`define CMF_REG_CTRL      8'h00
`define CMF_REG_STATUS    8'h01
`define CMF_REG_IN_BASE   8'h10
`define CMF_REG_IN_LAST   8'h23
`define CMF_FLD_SEL       2'h0
`define CMF_FLD_MIN       2'h1
`define CMF_FLD_MAX       2'h2
`define CMF_FLD_WGT       2'h3
`define CMF_REG_OP_BASE   8'h30
`define CMF_REG_OP_LAST   8'h33
`define CMF_REG_OUT_MIN   8'h38
`define CMF_REG_OUT_MAX   8'h39
`define CMF_REG_RES_PCT   8'h3a
`define CMF_REG_RES_PHYS  8'h3b

`define CMF_CTRL_EN_BIT   0
`define CMF_RST_OUT_MIN   32'h00000000
`define CMF_RST_OUT_MAX   32'h00000064
`define CMF_RST_IN_MIN    32'h00000000
`define CMF_RST_IN_MAX    32'h00000064

`endif

// *** core/cmf_stage.v ***
// one operator stage of the chained math block
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"

module cmf_stage (
  input  wire [3:0]             op_in,
  input  wire                   b_used_in,
  input  wire signed [31:0]     a_in,
  input  wire signed [31:0]     b_in,
  output reg  signed [31:0]     y_out
);

  function signed [31:0] cmf_sat_pct;
    input signed [63:0] v;
    begin
      if (v > $signed({32'h00000000, `CMF_PCT_FULL}))
        cmf_sat_pct = `CMF_PCT_FULL;
      else if (v < 64'sd0)
        cmf_sat_pct = `CMF_PCT_ZERO;
      else
        cmf_sat_pct = v[31:0];
    end
  endfunction

  function signed [31:0] cmf_bool;
    input b;
    begin
      cmf_bool = b ? `CMF_PCT_ONE : `CMF_PCT_ZERO;
    end
  endfunction

  wire signed [63:0] a_w = {{32{a_in[31]}}, a_in};
  wire signed [63:0] b_w = {{32{b_in[31]}}, b_in};
  wire signed [63:0] full_w = {32'h00000000, `CMF_PCT_FULL};
  wire               a_true = (a_in >= $signed(`CMF_PCT_ONE));
  wire               b_true = (b_in >= $signed(`CMF_PCT_ONE));
  wire signed [63:0] prod = a_w * b_w;
  wire signed [63:0] quot = (b_in == 32'sd0) ? full_w : (a_w * full_w) / b_w;

  always @* begin
    if (!b_used_in) begin
      y_out = a_in;
    end else begin
      case (op_in)
        `CMF_OP_EQ:  y_out = cmf_bool(a_in == b_in);
        `CMF_OP_NE:  y_out = cmf_bool(a_in != b_in);
        `CMF_OP_GT:  y_out = cmf_bool(a_in > b_in);
        `CMF_OP_GE:  y_out = cmf_bool(a_in >= b_in);
        `CMF_OP_LT:  y_out = cmf_bool(a_in < b_in);
        `CMF_OP_LE:  y_out = cmf_bool(a_in <= b_in);
        `CMF_OP_OR:  y_out = cmf_bool(a_true | b_true);
        `CMF_OP_AND: y_out = cmf_bool(a_true & b_true);
        `CMF_OP_XOR: y_out = cmf_bool(a_true ^ b_true);
        `CMF_OP_ADD: y_out = cmf_sat_pct(a_w + b_w);
        `CMF_OP_SUB: y_out = cmf_sat_pct(a_w - b_w);
        `CMF_OP_MUL: y_out = cmf_sat_pct(prod / full_w);
        `CMF_OP_DIV: y_out = cmf_sat_pct(quot);
        `CMF_OP_MIN: y_out = cmf_sat_pct((a_in < b_in) ? a_w : b_w);
        `CMF_OP_MAX: y_out = cmf_sat_pct((a_in > b_in) ? a_w : b_w);
        // unknown codes behave as unused, safer than a random result
        default:     y_out = a_in;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** core/cmf_top.v ***
// chained math function block: registers, input scaling, stage chain, output map
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"

module cmf_top #(
  parameter [3:0] INSTANCE = 4'h1
) (
  input  wire                   sys_clk_in,
  input  wire                   rst_in,
  input  wire [7:0]             reg_addr_in,
  input  wire [31:0]            reg_wdata_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  output reg  [31:0]            reg_rdata_out,
  input  wire                   tick_in,
  input  wire [255:0]           src_values_in,
  input  wire [3:0]             query_type_in,
  input  wire [3:0]             query_num_in,
  output reg                    query_match_out,
  output reg  [31:0]            range_min_out,
  output reg  [31:0]            range_max_out,
  output reg  [31:0]            result_pct_out,
  output reg  [31:0]            result_phys_out,
  output reg                    result_valid_out
);

  // configuration state
  reg                enable_r;
  reg  [3:0]         sel_r    [0:4];
  reg  [31:0]        in_min_r [0:4];
  reg  [31:0]        in_max_r [0:4];
  reg  [15:0]        wgt_r    [0:4];
  reg  [3:0]         op_r     [0:3];
  reg  [31:0]        out_min_r;
  reg  [31:0]        out_max_r;
  reg                updated_r;
  reg  [15:0]        tick_cnt_r;
  integer            i;

  // address decode
  wire               in_hit   = (reg_addr_in >= `CMF_REG_IN_BASE) &&
                                (reg_addr_in <= `CMF_REG_IN_LAST);
  wire [7:0]         in_off   = reg_addr_in - `CMF_REG_IN_BASE;
  wire [2:0]         in_idx   = in_off[4:2];
  wire [1:0]         in_fld   = in_off[1:0];
  wire               op_hit   = (reg_addr_in >= `CMF_REG_OP_BASE) &&
                                (reg_addr_in <= `CMF_REG_OP_LAST);
  wire [7:0]         op_off   = reg_addr_in - `CMF_REG_OP_BASE;
  wire [1:0]         op_idx   = op_off[1:0];

  // weight limited to -1.0..1.0 on write
  function [15:0] cmf_clip_wgt;
    input [31:0] v;
    begin
      if ($signed(v) > $signed({16'h0000, `CMF_WGT_ONE}))
        cmf_clip_wgt = `CMF_WGT_ONE;
      else if ($signed(v) < $signed({16'hffff, `CMF_WGT_NEG_ONE}))
        cmf_clip_wgt = `CMF_WGT_NEG_ONE;
      else
        cmf_clip_wgt = v[15:0];
    end
  endfunction

  // pick a raw source value; codes outside 1..8 read as zero
  function [31:0] cmf_pick;
    input [3:0]   sel;
    input [255:0] vals;
    reg   [2:0]   k;
    begin
      k = 3'h0;
      if (sel == `CMF_SRC_UNUSED || sel > 4'h8) begin
        cmf_pick = 32'h00000000;
      end else begin
        k = sel[2:0] - 3'h1;
        cmf_pick = vals[k*32 +: 32];
      end
    end
  endfunction

  // raw value to weighted percent; a zero span gives zero rather than a divide fault
  function signed [31:0] cmf_norm;
    input signed [31:0] x;
    input signed [31:0] mn;
    input signed [31:0] mx;
    input signed [15:0] w;
    reg   signed [63:0] den;
    reg   signed [63:0] pct;
    reg   signed [63:0] wp;
    begin
      den = $signed({{32{mx[31]}}, mx}) - $signed({{32{mn[31]}}, mn});
      pct = 64'sd0;
      // every operand signed, else a negative weight or span turns into a huge positive
      if (den != 64'sd0)
        pct = (($signed({{32{x[31]}}, x}) - $signed({{32{mn[31]}}, mn})) *
               $signed({32'h00000000, `CMF_PCT_FULL})) / den;
      wp = (pct * $signed({{48{w[15]}}, w})) >>> `CMF_WGT_FRAC;
      if (wp > 64'sh000000007fffffff)
        cmf_norm = 32'sh7fffffff;
      else if (wp < -64'sh0000000080000000)
        cmf_norm = 32'sh80000000;
      else
        cmf_norm = wp[31:0];
    end
  endfunction

  // five scaled inputs: index 0 is stage one operand a, 1..4 operand b of each stage
  wire signed [31:0] scaled [0:4];
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_in
      assign scaled[g] = cmf_norm(cmf_pick(sel_r[g], src_values_in),
                                  in_min_r[g], in_max_r[g], wgt_r[g]);
    end
  endgenerate

  // stage chain
  wire signed [31:0] chain [0:4];
  assign chain[0] = scaled[0];
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_stage
      cmf_stage u_stage (
        .op_in     (op_r[g]),
        .b_used_in (sel_r[g+1] != `CMF_SRC_UNUSED),
        .a_in      (chain[g]),
        .b_in      (scaled[g+1]),
        .y_out     (chain[g+1])
      );
    end
  endgenerate

  // percent to physical units
  wire signed [63:0] span = {{32{out_max_r[31]}}, out_max_r} -
                            {{32{out_min_r[31]}}, out_min_r};
  wire signed [63:0] pct64 = {{32{chain[4][31]}}, chain[4]};
  wire signed [63:0] phys64 = $signed({{32{out_min_r[31]}}, out_min_r}) +
                              (pct64 * span) / $signed({32'h00000000, `CMF_PCT_FULL});

  // register writes and configuration
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_r  <= 1'b0;
      out_min_r <= `CMF_RST_OUT_MIN;
      out_max_r <= `CMF_RST_OUT_MAX;
      for (i = 0; i < 5; i = i + 1) begin
        sel_r[i]    <= `CMF_SRC_UNUSED;
        in_min_r[i] <= `CMF_RST_IN_MIN;
        in_max_r[i] <= `CMF_RST_IN_MAX;
        wgt_r[i]    <= `CMF_WGT_ONE;
      end
      for (i = 0; i < 4; i = i + 1) begin
        op_r[i] <= `CMF_OP_ADD;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == `CMF_REG_CTRL) begin
        enable_r <= reg_wdata_in[`CMF_CTRL_EN_BIT];
      end else if (reg_addr_in == `CMF_REG_OUT_MIN) begin
        out_min_r <= reg_wdata_in;
      end else if (reg_addr_in == `CMF_REG_OUT_MAX) begin
        out_max_r <= reg_wdata_in;
      end else if (op_hit) begin
        op_r[op_idx] <= reg_wdata_in[3:0];
      end else if (in_hit) begin
        case (in_fld)
          `CMF_FLD_SEL: sel_r[in_idx]    <= reg_wdata_in[3:0];
          `CMF_FLD_MIN: in_min_r[in_idx] <= reg_wdata_in;
          `CMF_FLD_MAX: in_max_r[in_idx] <= reg_wdata_in;
          `CMF_FLD_WGT: wgt_r[in_idx]    <= cmf_clip_wgt(reg_wdata_in);
          default:      sel_r[in_idx]    <= sel_r[in_idx];
        endcase
      end
    end
  end

  // evaluation on the update tick
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_pct_out   <= 32'h00000000;
      result_phys_out  <= `CMF_RST_OUT_MIN;
      result_valid_out <= 1'b0;
      updated_r        <= 1'b0;
      tick_cnt_r       <= 16'h0000;
    end else begin
      result_valid_out <= 1'b0;
      if (tick_in && enable_r) begin
        result_pct_out   <= chain[4];
        result_phys_out  <= phys64[31:0];
        result_valid_out <= 1'b1;
        updated_r        <= 1'b1;
        tick_cnt_r       <= tick_cnt_r + 16'h0001;
      end
    end
  end

  // range limits and source matching seen by downstream blocks
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      range_min_out   <= `CMF_RST_OUT_MIN;
      range_max_out   <= `CMF_RST_OUT_MAX;
      query_match_out <= 1'b0;
    end else begin
      range_min_out   <= out_min_r;
      range_max_out   <= out_max_r;
      query_match_out <= (query_type_in == `CMF_SRC_TYPE_MATH) &&
                         (query_num_in == INSTANCE);
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= 32'h00000000;
      if (reg_rd_in) begin
        if (reg_addr_in == `CMF_REG_CTRL)
          reg_rdata_out <= {31'h00000000, enable_r};
        else if (reg_addr_in == `CMF_REG_STATUS)
          reg_rdata_out <= {tick_cnt_r, 15'h0000, updated_r};
        else if (reg_addr_in == `CMF_REG_OUT_MIN)
          reg_rdata_out <= out_min_r;
        else if (reg_addr_in == `CMF_REG_OUT_MAX)
          reg_rdata_out <= out_max_r;
        else if (reg_addr_in == `CMF_REG_RES_PCT)
          reg_rdata_out <= result_pct_out;
        else if (reg_addr_in == `CMF_REG_RES_PHYS)
          reg_rdata_out <= result_phys_out;
        else if (op_hit)
          reg_rdata_out <= {28'h0000000, op_r[op_idx]};
        else if (in_hit) begin
          case (in_fld)
            `CMF_FLD_SEL: reg_rdata_out <= {28'h0000000, sel_r[in_idx]};
            `CMF_FLD_MIN: reg_rdata_out <= in_min_r[in_idx];
            `CMF_FLD_MAX: reg_rdata_out <= in_max_r[in_idx];
            `CMF_FLD_WGT: reg_rdata_out <= {{16{wgt_r[in_idx][15]}}, wgt_r[in_idx]};
            default:      reg_rdata_out <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** test/cmf_partner.sv ***
// model of the neighbouring blocks that supply raw source values
`timescale 1ns/1ps
`default_nettype none
module cmf_partner (
  input  wire logic         clk_in,
  output logic [255:0]      src_values_out
);
  initial src_values_out = 256'h0;
  // producers update just after an edge, never in the sampling step
  task set_src(input int k, input logic [31:0] v);
    @(posedge clk_in);
    src_values_out[(k-1)*32 +: 32] <= v;
  endtask
endmodule
`default_nettype wire

// *** test/cmf_top_checker.sv ***
// port assertions for the chained math block
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"
module cmf_top_checker #(
  parameter [3:0] INSTANCE = 4'h1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [7:0]   reg_addr_in,
  input  wire logic [31:0]  reg_wdata_in,
  input  wire logic         reg_wr_in,
  input  wire logic         reg_rd_in,
  input  wire logic [31:0]  reg_rdata_out,
  input  wire logic         tick_in,
  input  wire logic [255:0] src_values_in,
  input  wire logic [3:0]   query_type_in,
  input  wire logic [3:0]   query_num_in,
  input  wire logic         query_match_out,
  input  wire logic [31:0]  range_min_out,
  input  wire logic [31:0]  range_max_out,
  input  wire logic [31:0]  result_pct_out,
  input  wire logic [31:0]  result_phys_out,
  input  wire logic         result_valid_out
);
  logic en_r;
  // mirror of the enable bit; tick acceptance hangs on it
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in) en_r <= 1'b0;
    else if (reg_wr_in && reg_addr_in == `CMF_REG_CTRL) en_r <= reg_wdata_in[0];
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_valid_on_tick: assert property ((tick_in && en_r) |=> result_valid_out)
    else $error("no valid after an enabled tick");
  a_valid_needs_tick: assert property (result_valid_out |-> $past(tick_in && en_r))
    else $error("valid without an enabled tick");
  a_result_holds: assert property (!result_valid_out |-> $stable(result_pct_out)
    && $stable(result_phys_out)) else $error("result moved without valid");
  a_match_hit: assert property ((query_type_in == `CMF_SRC_TYPE_MATH
    && query_num_in == INSTANCE) |=> query_match_out) else $error("query not matched");
  a_match_miss: assert property (!(query_type_in == `CMF_SRC_TYPE_MATH
    && query_num_in == INSTANCE) |=> !query_match_out) else $error("false query match");
  // range copy lags the setting register by one more edge
  a_range_min_copy: assert property ((reg_wr_in && reg_addr_in == `CMF_REG_OUT_MIN)
    |=> ##1 range_min_out == $past(reg_wdata_in, 2)) else $error("range minimum not reported");
  a_range_max_copy: assert property ((reg_wr_in && reg_addr_in == `CMF_REG_OUT_MAX)
    |=> ##1 range_max_out == $past(reg_wdata_in, 2)) else $error("range maximum not reported");
  a_range_max_hold: assert property (!(reg_wr_in && reg_addr_in == `CMF_REG_OUT_MAX)
    ##1 !(reg_wr_in && reg_addr_in == `CMF_REG_OUT_MAX) |=> $stable(range_max_out))
    else $error("range maximum changed unasked");
  a_phys_at_full: assert property ((result_valid_out && result_pct_out == `CMF_PCT_FULL)
    |-> result_phys_out == range_max_out) else $error("full scale not at output maximum");
  a_phys_at_zero: assert property ((result_valid_out && result_pct_out == `CMF_PCT_ZERO)
    |-> result_phys_out == range_min_out) else $error("zero not at output minimum");
endmodule
bind cmf_top cmf_top_checker #(.INSTANCE(INSTANCE)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .tick_in(tick_in), .src_values_in(src_values_in),
  .query_type_in(query_type_in), .query_num_in(query_num_in),
  .query_match_out(query_match_out), .range_min_out(range_min_out),
  .range_max_out(range_max_out), .result_pct_out(result_pct_out),
  .result_phys_out(result_phys_out), .result_valid_out(result_valid_out));
`default_nettype wire

// *** test/cmf_top_tb.sv ***
// self-checking bench for the chained math block
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"
module cmf_top_tb;
  logic         sys_clk_in    = 1'b0;
  logic         rst_in        = 1'b1;
  logic [7:0]   reg_addr_in   = 8'h00;
  logic [31:0]  reg_wdata_in  = 32'h0;
  logic         reg_wr_in     = 1'b0;
  logic         reg_rd_in     = 1'b0;
  logic         tick_in       = 1'b0;
  logic [3:0]   query_type_in = 4'h0;
  logic [3:0]   query_num_in  = 4'h0;
  wire  [255:0] src_values;
  wire  [31:0]  rdata, rng_min, rng_max, res_pct, res_phys;
  wire          match, valid;
  int           mismatches    = 0;
  int           total_checks  = 0;
  // stage one with a = 50 %, b = 25 %, codes 0..15; code 15 passes a
  logic [31:0]  exp_tab [16]  = '{32'h0, 32'h100, 32'h100, 32'h100, 32'h0, 32'h0, 32'h100,
    32'h100, 32'h0, 32'h4b00, 32'h1900, 32'h0c80, 32'h6400, 32'h1900, 32'h3200, 32'h3200};
  cmf_partner p (.clk_in(sys_clk_in), .src_values_out(src_values));
  cmf_top uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .tick_in(tick_in), .src_values_in(src_values),
    .query_type_in(query_type_in), .query_num_in(query_num_in), .query_match_out(match),
    .range_min_out(rng_min), .range_max_out(rng_max), .result_pct_out(res_pct),
    .result_phys_out(res_phys), .result_valid_out(valid));
  always #2 sys_clk_in = ~sys_clk_in;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // one tick, then a bounded wait for the valid pulse
  task automatic run_tick(input logic [31:0] pct);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    tick_in <= 1'b1;
    @(posedge sys_clk_in);
    tick_in <= 1'b0;
    #1;
    while (valid !== 1'b1 && n < 8) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (valid !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    check(res_pct, pct);
  endtask
  task automatic query(input logic [3:0] t, input logic [3:0] n, input logic e);
    @(posedge sys_clk_in);
    query_type_in <= t;
    query_num_in <= n;
    @(posedge sys_clk_in);
    #1 check({31'h0, match}, {31'h0, e});
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rdchk(`CMF_REG_OUT_MAX, 32'h64);
    check(rng_max, 32'h64);
    rdchk(8'h13, 32'h4000);
    rdchk(8'hff, 32'h0);
    p.set_src(1, 32'd70);
    p.set_src(2, 32'd25);
    wr(8'h10, 32'h1);
    wr(8'h11, 32'd20);
    wr(8'h12, 32'd120);
    wr(8'h14, 32'h2);
    wr(`CMF_REG_CTRL, 32'h1);
    for (int op = 0; op < 16; op++) begin
      wr(`CMF_REG_OP_BASE, 32'(op));
      run_tick(exp_tab[op]);
    end
    wr(`CMF_REG_OP_BASE, 32'h9);
    wr(8'h17, 32'hffffc000);
    run_tick(32'h1900);
    wr(8'h17, 32'h8000);
    rdchk(8'h17, 32'h4000);
    wr(8'h17, 32'hffff0000);
    rdchk(8'h17, 32'hffffc000);
    wr(8'h17, 32'h4000);
    p.set_src(2, 32'd90);
    run_tick(32'h6400);
    wr(`CMF_REG_OP_BASE, 32'ha);
    run_tick(32'h0);
    p.set_src(2, 32'd0);
    wr(`CMF_REG_OP_BASE, 32'hc);
    run_tick(32'h6400);
    p.set_src(2, 32'd1);
    wr(`CMF_REG_OP_BASE, 32'h7);
    run_tick(32'h100);
    wr(8'h16, 32'd200);
    run_tick(32'h0);
    wr(8'h16, 32'd100);
    wr(8'h14, 32'h0);
    wr(`CMF_REG_OP_BASE, 32'h0);
    run_tick(32'h3200);
    // three live stages, so a wrong chaining order gives another value
    p.set_src(2, 32'd25);
    p.set_src(3, 32'd10);
    p.set_src(4, 32'd90);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    wr(8'h1c, 32'h4);
    wr(`CMF_REG_OP_BASE, 32'h9);
    wr(8'h31, 32'ha);
    wr(8'h32, 32'hd);
    wr(8'h33, 32'h0);
    wr(`CMF_REG_OUT_MIN, 32'h3e8);
    wr(`CMF_REG_OUT_MAX, 32'h7d0);
    run_tick(32'h4100);
    check(res_phys, 32'h672);
    check(rng_min, 32'h3e8);
    query(4'h6, 4'h1, 1'b1);
    query(4'h5, 4'h1, 1'b0);
    query(4'h6, 4'h2, 1'b0);
    wr(`CMF_REG_CTRL, 32'h0);
    @(posedge sys_clk_in);
    tick_in <= 1'b1;
    @(posedge sys_clk_in);
    tick_in <= 1'b0;
    #1 check({31'h0, valid}, 32'h0);
    check(res_pct, 32'h4100);
    rdchk(`CMF_REG_RES_PCT, 32'h4100);
    rdchk(`CMF_REG_RES_PHYS, 32'h672);
    rdchk(`CMF_REG_CTRL, 32'h0);
    // 24 evaluated ticks, the disabled one not counted
    rdchk(`CMF_REG_STATUS, 32'h00180001);
    print_verdict();
  end
endmodule
`default_nettype wire
